// ### fdsl_pkg.sv
// constants and the step function shared by the fan duty slew limiter
package fdsl_pkg;

  // register offsets
  localparam logic [7:0] FDSL_ADDR_DUTY1 = 8'h30;
  localparam logic [7:0] FDSL_ADDR_DUTY2 = 8'h31;
  localparam logic [7:0] FDSL_ADDR_DUTY3 = 8'h32;
  localparam logic [7:0] FDSL_ADDR_CFG1 = 8'h5C;
  localparam logic [7:0] FDSL_ADDR_CFG2 = 8'h5D;
  localparam logic [7:0] FDSL_ADDR_CFG3 = 8'h5E;
  localparam logic [7:0] FDSL_ADDR_RAMP1 = 8'h62;
  localparam logic [7:0] FDSL_ADDR_RAMP2 = 8'h63;

  // reset values
  localparam logic [7:0] FDSL_RST_CFG = 8'h00;
  localparam logic [7:0] FDSL_RST_RAMP = 8'h00;
  localparam logic [7:0] FDSL_RST_DUTY = 8'h00;

  // field positions
  localparam int FDSL_SLOW_BIT = 3;
  localparam int FDSL_EN1_BIT = 3;
  localparam int FDSL_EN2_BIT = 7;
  localparam int FDSL_EN3_BIT = 3;
  localparam int FDSL_CODE1_LSB = 0;
  localparam int FDSL_CODE2_LSB = 4;
  localparam int FDSL_CODE3_LSB = 0;
  localparam int FDSL_CODE_W = 3;

  // drive period in slots, and slot length in clock cycles
  localparam logic [7:0] FDSL_SLOTS = 8'hFF;
  localparam logic [7:0] FDSL_SLOT_MAX = 8'hFE;
  localparam logic [7:0] FDSL_SLOT_CYCLES = 8'h04;
  localparam logic [7:0] FDSL_ONE8 = 8'h01;

  // slow setting: last count value; one step per this many calculations plus one
  localparam logic [1:0] FDSL_SLOW_LAST = 2'h3;

  // step sizes in slots per rate code
  localparam logic [7:0] FDSL_STEP0 = 8'h01;
  localparam logic [7:0] FDSL_STEP1 = 8'h02;
  localparam logic [7:0] FDSL_STEP2 = 8'h03;
  localparam logic [7:0] FDSL_STEP3 = 8'h05;
  localparam logic [7:0] FDSL_STEP4 = 8'h08;
  localparam logic [7:0] FDSL_STEP5 = 8'h0C;
  localparam logic [7:0] FDSL_STEP6 = 8'h18;
  localparam logic [7:0] FDSL_STEP7 = 8'h30;

  function automatic logic [7:0] fdsl_step(input logic [2:0] code);
    logic [7:0] s;
    s = FDSL_STEP0;
    case (code)
      3'h0: s = FDSL_STEP0;
      3'h1: s = FDSL_STEP1;
      3'h2: s = FDSL_STEP2;
      3'h3: s = FDSL_STEP3;
      3'h4: s = FDSL_STEP4;
      3'h5: s = FDSL_STEP5;
      3'h6: s = FDSL_STEP6;
      3'h7: s = FDSL_STEP7;
      default: s = FDSL_STEP0;
    endcase
    return s;
  endfunction

endpackage

// ### fdsl_ramp.sv
// one output's duty slew limiter
`timescale 1ns/1ps
`default_nettype none
module fdsl_ramp
  import fdsl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire logic i_slow,
  input wire logic [2:0] i_code,
  input wire logic [7:0] i_calc_duty,
  input wire logic i_calc_valid,
  output logic [7:0] o_duty
);

  typedef struct packed {
    logic [7:0] duty;
    logic [1:0] slow_cnt;
  } fdsl_ramp_state_type;

  fdsl_ramp_state_type st_q;
  fdsl_ramp_state_type st_d;

  always_comb begin
    logic [7:0] step;
    logic [7:0] diff;
    logic do_step;
    step = fdsl_step(i_code);
    diff = 8'h00;
    do_step = 1'b0;
    st_d = st_q;
    if (i_calc_valid) begin
      if (!i_enable) begin
        st_d.duty = i_calc_duty;
        st_d.slow_cnt = 2'h0;
      end else begin
        // slow mode steps on the last of every four calculations
        if (i_slow && st_q.slow_cnt != FDSL_SLOW_LAST) begin
          st_d.slow_cnt = st_q.slow_cnt + 2'h1;
        end else begin
          st_d.slow_cnt = 2'h0;
          do_step = 1'b1;
        end
      end
    end
    if (do_step) begin
      if (i_calc_duty > st_q.duty) begin
        diff = i_calc_duty - st_q.duty;
        if (diff <= step) begin
          st_d.duty = i_calc_duty;
        end else begin
          st_d.duty = st_q.duty + step;
        end
      end else if (i_calc_duty < st_q.duty) begin
        diff = st_q.duty - i_calc_duty;
        if (diff <= step) begin
          st_d.duty = i_calc_duty;
        end else begin
          st_d.duty = st_q.duty - step;
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st_q <= '{duty: FDSL_RST_DUTY, slow_cnt: 2'h0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_duty = st_q.duty;

endmodule
`default_nettype wire

// ### fdsl_pwm.sv
// 255-slot drive waveform for one fan output
`timescale 1ns/1ps
`default_nettype none
module fdsl_pwm
  import fdsl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_duty,
  output logic o_drive
);

  typedef struct packed {
    logic [7:0] presc;
    logic [7:0] slot;
    logic [7:0] duty;
    logic drive;
  } fdsl_pwm_state_type;

  fdsl_pwm_state_type st_q;
  fdsl_pwm_state_type st_d;

  always_comb begin
    st_d = st_q;
    if (st_q.presc == FDSL_SLOT_CYCLES - FDSL_ONE8) begin
      st_d.presc = 8'h00;
      if (st_q.slot == FDSL_SLOT_MAX) begin
        st_d.slot = 8'h00;
        // duty taken only at period start: no runt pulses
        st_d.duty = i_duty;
      end else begin
        st_d.slot = st_q.slot + FDSL_ONE8;
      end
    end else begin
      st_d.presc = st_q.presc + FDSL_ONE8;
    end
    st_d.drive = (st_d.slot < st_d.duty);
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st_q <= '{presc: 8'h00, slot: 8'h00, duty: FDSL_RST_DUTY,
                drive: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_drive = st_q.drive;

endmodule
`default_nettype wire

// ### fdsl_top.sv
// fan duty slew limiter: registers, three ramps, three drive outputs
`timescale 1ns/1ps
`default_nettype none
module fdsl_top
  import fdsl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic [7:0] i_calc_duty1,
  input wire logic [7:0] i_calc_duty2,
  input wire logic [7:0] i_calc_duty3,
  input wire logic i_calc_valid,
  output logic [7:0] o_applied_duty1,
  output logic [7:0] o_applied_duty2,
  output logic [7:0] o_applied_duty3,
  output logic o_fan_output_1,
  output logic o_fan_output_2,
  output logic o_fan_output_3
);

  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic [7:0] ramp1;
    logic [7:0] ramp2;
    logic [7:0] rdata;
  } fdsl_regs_type;

  fdsl_regs_type st_q;
  fdsl_regs_type st_d;

  logic [2:0] enable;
  logic [2:0] slow;
  logic [2:0][2:0] code;
  logic [2:0][7:0] calc;
  logic [2:0][7:0] duty;
  logic [2:0] drive;

  ////////////////////////////////////////////////////////////////////
  // register port

  always_comb begin
    st_d = st_q;
    if (i_reg_wr) begin
      case (i_reg_addr)
        FDSL_ADDR_CFG1: st_d.cfg1 = i_reg_wdata;
        FDSL_ADDR_CFG2: st_d.cfg2 = i_reg_wdata;
        FDSL_ADDR_CFG3: st_d.cfg3 = i_reg_wdata;
        FDSL_ADDR_RAMP1: st_d.ramp1 = i_reg_wdata;
        FDSL_ADDR_RAMP2: st_d.ramp2 = i_reg_wdata;
        default: st_d.rdata = st_q.rdata;
      endcase
    end
    if (i_reg_rd) begin
      // applied duty readback shows the ramp's live state
      case (i_reg_addr)
        FDSL_ADDR_DUTY1: st_d.rdata = duty[0];
        FDSL_ADDR_DUTY2: st_d.rdata = duty[1];
        FDSL_ADDR_DUTY3: st_d.rdata = duty[2];
        FDSL_ADDR_CFG1: st_d.rdata = st_q.cfg1;
        FDSL_ADDR_CFG2: st_d.rdata = st_q.cfg2;
        FDSL_ADDR_CFG3: st_d.rdata = st_q.cfg3;
        FDSL_ADDR_RAMP1: st_d.rdata = st_q.ramp1;
        FDSL_ADDR_RAMP2: st_d.rdata = st_q.ramp2;
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st_q <= '{cfg1: FDSL_RST_CFG, cfg2: FDSL_RST_CFG,
                cfg3: FDSL_RST_CFG, ramp1: FDSL_RST_RAMP,
                ramp2: FDSL_RST_RAMP, rdata: 8'h00};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_reg_rdata = st_q.rdata;

  ////////////////////////////////////////////////////////////////////
  // field decode, one set per output

  assign enable[0] = st_q.ramp1[FDSL_EN1_BIT];
  assign enable[1] = st_q.ramp2[FDSL_EN2_BIT];
  assign enable[2] = st_q.ramp2[FDSL_EN3_BIT];
  assign code[0] = st_q.ramp1[FDSL_CODE1_LSB +: FDSL_CODE_W];
  assign code[1] = st_q.ramp2[FDSL_CODE2_LSB +: FDSL_CODE_W];
  assign code[2] = st_q.ramp2[FDSL_CODE3_LSB +: FDSL_CODE_W];
  assign slow[0] = st_q.cfg1[FDSL_SLOW_BIT];
  assign slow[1] = st_q.cfg2[FDSL_SLOW_BIT];
  assign slow[2] = st_q.cfg3[FDSL_SLOW_BIT];
  assign calc[0] = i_calc_duty1;
  assign calc[1] = i_calc_duty2;
  assign calc[2] = i_calc_duty3;

  ////////////////////////////////////////////////////////////////////
  // independent ramp and drive per output

  for (genvar g = 0; g < 3; g++) begin : g_out
    fdsl_ramp u_ramp (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_enable(enable[g]),
      .i_slow(slow[g]),
      .i_code(code[g]),
      .i_calc_duty(calc[g]),
      .i_calc_valid(i_calc_valid),
      .o_duty(duty[g])
    );
    fdsl_pwm u_pwm (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_duty(duty[g]),
      .o_drive(drive[g])
    );
  end

  assign o_applied_duty1 = duty[0];
  assign o_applied_duty2 = duty[1];
  assign o_applied_duty3 = duty[2];
  assign o_fan_output_1 = drive[0];
  assign o_fan_output_2 = drive[1];
  assign o_fan_output_3 = drive[2];

endmodule
`default_nettype wire

// ### fdsl_fan.sv
// fan model: integrates the drive waveform's high time
`timescale 1ns/1ps
`default_nettype none
module fdsl_fan
(
  input wire logic i_clock,
  input wire logic i_clear,
  input wire logic i_drive,
  output var logic [15:0] o_high
);
  // averaged speed stands in as high clocks since the last clear
  always_ff @(posedge i_clock) begin
    if (i_clear) begin
      o_high <= 16'h0000;
    end else if (i_drive) begin
      o_high <= o_high + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ### fdsl_chk.sv
// checker on the slew limiter's top-level ports
`timescale 1ns/1ps
`default_nettype none
module fdsl_chk
  import fdsl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [7:0] i_calc_duty1,
  input wire logic [7:0] i_calc_duty2,
  input wire logic [7:0] i_calc_duty3,
  input wire logic i_calc_valid,
  input wire logic [7:0] o_applied_duty1,
  input wire logic [7:0] o_applied_duty2,
  input wire logic [7:0] o_applied_duty3,
  input wire logic o_fan_output_1,
  input wire logic o_fan_output_2,
  input wire logic o_fan_output_3
);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////
  a_reset_idle: assert property ($fell(i_sys_rst) |->
    o_applied_duty1 == 8'h00 && !o_fan_output_1) else $error("not idle");
  a_up_toward: assert property (
    i_calc_valid && i_calc_duty1 >= o_applied_duty1 |=>
    o_applied_duty1 >= $past(o_applied_duty1) &&
    o_applied_duty1 <= $past(i_calc_duty1)) else $error("duty1 off");
  a_down_toward: assert property (
    i_calc_valid && i_calc_duty2 <= o_applied_duty2 |=>
    o_applied_duty2 <= $past(o_applied_duty2) &&
    o_applied_duty2 >= $past(i_calc_duty2)) else $error("duty2 off");
  a_duty_hold: assert property (!i_calc_valid |=>
    $stable(o_applied_duty3)) else $error("duty3 moved");
  a_rdata_hold: assert property (!i_reg_rd |=>
    $stable(o_reg_rdata)) else $error("rdata moved");
  a_unmapped_zero: assert property (
    i_reg_rd && i_reg_addr == 8'h00 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read");
  a_ramp_readback: assert property (
    i_reg_wr && i_reg_addr == FDSL_ADDR_RAMP1 ##1 !i_reg_wr ##1
    i_reg_rd && i_reg_addr == FDSL_ADDR_RAMP1 |=>
    o_reg_rdata == $past(i_reg_wdata, 3)) else $error("readback");
  a_duty_readonly: assert property (
    i_reg_wr && i_reg_addr == FDSL_ADDR_DUTY1 && !i_calc_valid |=>
    $stable(o_applied_duty1)) else $error("duty written");
endmodule
`default_nettype wire

// ### fdsl_top_test.sv
// self-checking bench for the fan duty slew limiter
`timescale 1ns/1ps
`default_nettype none
module fdsl_top_test;
  import fdsl_pkg::*;
  logic i_clock = 1'b0, i_sys_rst = 1'b1, clr = 1'b0;
  logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_calc_valid = 1'b0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
  logic [7:0] i_calc_duty1 = 8'h00, i_calc_duty2 = 8'h00;
  logic [7:0] i_calc_duty3 = 8'h00;
  logic [7:0] o_applied_duty1, o_applied_duty2, o_applied_duty3;
  logic o_fan_output_1, o_fan_output_2, o_fan_output_3;
  logic [15:0] hi, hi2, hi3;
  logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C,
    8'h18, 8'h30};
  int bad_count = 0, check_count = 0;
  always #25 i_clock = ~i_clock;
  fdsl_top i_fdsl_top (.i_clock, .i_sys_rst, .i_reg_addr, .i_reg_wr,
    .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .i_calc_duty1, .i_calc_duty2,
    .i_calc_duty3, .i_calc_valid, .o_applied_duty1, .o_applied_duty2,
    .o_applied_duty3, .o_fan_output_1, .o_fan_output_2, .o_fan_output_3);
  fdsl_fan i_fdsl_fan (.i_clock, .i_clear(clr), .i_drive(o_fan_output_1),
    .o_high(hi));
  fdsl_fan i_fdsl_fan_2 (.i_clock, .i_clear(clr),
    .i_drive(o_fan_output_2), .o_high(hi2));
  fdsl_fan i_fdsl_fan_3 (.i_clock, .i_clear(clr),
    .i_drive(o_fan_output_3), .o_high(hi3));
  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d, errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // all bus tasks start and end at a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_clock);
    i_reg_wr = 1'b0;
    // idle cycle so a following write never re-raises wr at once
    @(negedge i_clock);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_clock);
    i_reg_rd = 1'b0;
    @(negedge i_clock);
    chk({8'h00, o_reg_rdata}, {8'h00, exp});
  endtask
  task automatic pulse(input logic [7:0] a, input logic [7:0] b);
    i_calc_duty1 = a;
    i_calc_duty2 = b;
    i_calc_duty3 = b;
    i_calc_valid = 1'b1;
    @(negedge i_clock);
    i_calc_valid = 1'b0;
    @(negedge i_clock);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge i_clock);
    i_sys_rst = 1'b0;
    rdc(FDSL_ADDR_CFG1, 8'h00);
    rdc(FDSL_ADDR_RAMP2, 8'h00);
    rdc(8'h00, 8'h00);
    wr(FDSL_ADDR_RAMP2, 8'h9A);
    pulse(8'h64, 8'hC8);
    chk({8'h00, o_applied_duty1}, 16'h0064);
    chk({8'h00, o_applied_duty2}, 16'h0002);
    chk({8'h00, o_applied_duty3}, 16'h0003);
    pulse(8'h64, 8'hC8);
    chk({8'h00, o_applied_duty2}, 16'h0004);
    chk({8'h00, o_applied_duty3}, 16'h0006);
    for (int k = 0; k < 8; k++) begin
      wr(FDSL_ADDR_RAMP1, 8'h00);
      pulse(8'h00, 8'h00);
      chk({8'h00, o_applied_duty1}, 16'h0000);
      wr(FDSL_ADDR_RAMP1, 8'h08 | 8'(k));
      rdc(FDSL_ADDR_RAMP1, 8'h08 | 8'(k));
      pulse(8'hC8, 8'h00);
      chk({8'h00, o_applied_duty1}, 16'(steps[k]));
      pulse(8'hC8, 8'h00);
      chk({8'h00, o_applied_duty1}, 16'(steps[k] + steps[k]));
    end
    pulse(8'h64, 8'h00);
    chk({8'h00, o_applied_duty1}, 16'h0064);
    wr(FDSL_ADDR_DUTY1, 8'hFF);
    rdc(FDSL_ADDR_DUTY1, 8'h64);
    pulse(8'h00, 8'h00);
    chk({8'h00, o_applied_duty1}, 16'h0034);
    pulse(8'h00, 8'h00);
    pulse(8'h00, 8'h00);
    chk({8'h00, o_applied_duty1}, 16'h0000);
    // disabled calculations load duty directly and restart slow counters, so clear enables first
    wr(FDSL_ADDR_RAMP1, 8'h00);
    wr(FDSL_ADDR_RAMP2, 8'h00);
    pulse(8'h00, 8'h00);
    chk({8'h00, o_applied_duty2}, 16'h0000);
    wr(FDSL_ADDR_CFG1, 8'h08);
    wr(FDSL_ADDR_CFG2, 8'h08);
    wr(FDSL_ADDR_CFG3, 8'h08);
    wr(FDSL_ADDR_RAMP1, 8'h0F);
    wr(FDSL_ADDR_RAMP2, 8'h9A);
    repeat (3) pulse(8'hC8, 8'hC8);
    chk({8'h00, o_applied_duty1}, 16'h0000);
    pulse(8'hC8, 8'hC8);
    chk({8'h00, o_applied_duty1}, 16'h0030);
    chk({8'h00, o_applied_duty2}, 16'h0002);
    chk({8'h00, o_applied_duty3}, 16'h0003);
    wr(FDSL_ADDR_RAMP1, 8'h00);
    pulse(8'h55, 8'h00);
    // one full period first so the new duty is latched at a wrap
    repeat (16'h03FC) @(negedge i_clock);
    clr = 1'b1;
    @(negedge i_clock);
    clr = 1'b0;
    repeat (16'h03FC) @(negedge i_clock);
    chk(hi, 16'h0154);
    // outputs 2 and 3 still hold 2 and 3 slots from the slow ramp
    chk(hi2, 16'h0008);
    chk(hi3, 16'h000C);
    // mid-run reset: registers and applied duty return to zero
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_clock);
    i_sys_rst = 1'b0;
    rdc(FDSL_ADDR_RAMP2, 8'h00);
    chk({8'h00, o_applied_duty3}, 16'h0000);
    stop_test();
  end
  initial begin
    #500us;
    bad_count++;
    stop_test();
  end
endmodule
bind fdsl_top fdsl_chk i_fdsl_chk (.i_clock, .i_sys_rst, .i_reg_addr,
  .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .i_calc_duty1,
  .i_calc_duty2, .i_calc_duty3, .i_calc_valid, .o_applied_duty1,
  .o_applied_duty2, .o_applied_duty3, .o_fan_output_1, .o_fan_output_2,
  .o_fan_output_3);
`default_nettype wire
